// File: design/dcpm_pkg.sv
/*
 * dcpm_pkg: shared constants and carriers for the two-channel pulse modulator.
 * assumes: a single 25 MHz bus clock; registers reached over AXI4-Lite, 32-bit words.
 */
package dcpm_pkg;
    // ==========================================================
    // register map, byte offsets inside one channel bank
    localparam logic [7:0] OFF_PRESCALE = 8'h00;
    localparam logic [7:0] OFF_PERIOD = 8'h04;
    localparam logic [7:0] OFF_PHASE = 8'h08;
    localparam logic [7:0] OFF_DUTY = 8'h0c;
    localparam logic [7:0] OFF_CTRL = 8'h10;
    localparam logic [7:0] OFF_RUN = 8'h14;
    localparam logic [7:0] OFF_COUNT = 8'h18;
    localparam logic [7:0] OFF_IRQ = 8'h1c;
    // bank bases relative to the block window (0xfff4_1000 and 0xfff4_1100)
    localparam logic [8:0] BANK0_BASE = 9'h000;
    localparam logic [8:0] BANK1_BASE = 9'h100;
    localparam int BANK_SEL_BIT = 8;
    localparam int ADDR_W = 9;
    // ==========================================================
    // field positions
    localparam int CTRL_POL_BIT = 0;
    localparam int CTRL_SINGLE_CYCLE_SELECT_BIT = 3;
    localparam int RUN_START_BIT = 0;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_SEL_LSB = 8;
    localparam logic [1:0] IRQ_SEL_DONE = 2'h1;
    localparam logic [15:0] FIELD_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // per-channel configuration carried into the channel engine
    typedef struct packed {
        logic [15:0] prescale;
        logic [15:0] period;
        logic [15:0] phase;
        logic [15:0] duty;
        logic single_cycle_select;
        logic polarity;
        logic run;
    } dcpm_cfg_t;

    typedef struct packed {
        logic [15:0] count;
        logic level;
        logic done;
    } dcpm_stat_t;
endpackage : dcpm_pkg

// File: design/dcpm_tick.sv
/*
 * dcpm_tick: base-tick divider, one enable pulse every prescale bus clocks.
 * assumes: prescale never zero while running; restart realigns the divider.
 */
`timescale 1ns/1ns
module dcpm_tick (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic run_i,
    input wire logic [15:0] prescale_i,
    // enable out
    output logic tick_o
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic wrap;

    assign wrap = run_i && (cnt_reg + 16'h0001 >= prescale_i);
    assign cnt_next = (!run_i || wrap) ? 16'h0000 : cnt_reg + 16'h0001;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 16'h0000;
            tick_o <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_o <= wrap; // [R4]
        end
    end
endmodule : dcpm_tick

// File: design/dcpm_chan.sv
/*
 * dcpm_chan: one pulse channel, counter, phase/duty compare and output level.
 * assumes: tick_i is a one-cycle enable from the prescaler.
 */
`timescale 1ns/1ns
module dcpm_chan (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // configuration and timing
    input wire dcpm_pkg::dcpm_cfg_t cfg_i,
    input wire logic tick_i,
    // state out
    output dcpm_pkg::dcpm_stat_t stat_o
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic last;
    logic active;
    logic [16:0] duty_end;

    assign last = (cnt_reg + 16'h0001 >= cfg_i.period);
    assign cnt_next = last ? 16'h0000 : cnt_reg + 16'h0001;
    assign duty_end = {1'b0, cfg_i.phase} + {1'b0, cfg_i.duty};
    // inactive for phase, active for duty, inactive to period end
    assign active = ({1'b0, cnt_next} >= {1'b0, cfg_i.phase})
        && ({1'b0, cnt_next} < duty_end); // [R21]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 16'h0000;
            stat_o <= '0;
        end else begin
            stat_o.done <= 1'b0;
            if (!cfg_i.run) begin
                cnt_reg <= 16'h0000; // [R22]
                stat_o.count <= 16'h0000;
                stat_o.level <= !cfg_i.polarity; // [R22] [R17]
            end else if (tick_i && !(stat_o.done && cfg_i.single_cycle_select)) begin
                // one-shot: no tick lands while the stop is on its way
                cnt_reg <= cnt_next; // [R22]
                stat_o.count <= cnt_next; // [R12]
                stat_o.level <= active ? cfg_i.polarity : !cfg_i.polarity; // [R17]
                stat_o.done <= last; // [R19]
            end
        end
    end
endmodule : dcpm_chan

// File: design/dcpm_top.sv
/*
 * dcpm_top: two-channel pulse modulator with an AXI4-Lite register slave.
 * assumes: 32-bit word accesses only; the pin multiplexer outside routes
 *          each pulse output to every location software has selected.
 */
// The AXI4-Lite register port was left to the implementer.
// How it works
// R1: two channels, bank 0 at first base, bank 1 at second base.
// R2: registers are accessed as whole 32-bit words only.
// R3: each channel holds its own duty, phase and polarity.
// R4: prescale field gives base tick every N bus clocks; zero prohibited.
// R5: period field is N base ticks; 0 and 1 prohibited.
// R6: phase field is N base ticks; zero prohibited.
// R7: duty field is N base ticks; zero prohibited.
// R8: control bit 3 picks continuous (0, reset) or one-shot (1).
// R9: control bits 2..1 reserved; software writes zero.
// R10: upper reserved bits ignore writes and read zero.
// R11: each channel has a start/stop register.
// R12: read-only register shows current count in base ticks.
// R13: interrupt register selects which status raises the interrupt.
// R14: selected cause raises an interrupt request to the controller.
// R15: system pin mux must select the pulse function to route pins.
// R16: several selected mux options all carry the pulse in parallel.
// R17: control bit 0 polarity: 0 negative (reset), 1 positive.
// R18: start bit 1 runs, 0 stops; one-shot clears it after cycle.
// R19: done flag sets after a pulse cycle; write one clears.
// R20: selector 01 enables done as cause, 00 disables.
// R21: output inactive for phase, active for duty, inactive to end.
// R22: counter advances per base tick, restarts each cycle; idle inactive.
`timescale 1ns/1ns
module dcpm_top #(
    parameter int NCH = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // axi4-lite write address and data
    input wire logic [dcpm_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi4-lite read
    input wire logic [dcpm_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // pulse outputs, one per channel, to the pin mux
    output logic [NCH-1:0] pulse_out_o,
    // interrupt requests, one per channel
    output logic [NCH-1:0] irq_o
);
    // ==========================================================
    // write path: address and data latched independently
    logic aw_held_reg;
    logic w_held_reg;
    logic [dcpm_pkg::ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;
    logic wr_full;
    logic wr_ok;
    logic [7:0] wr_off;
    logic wr_bank;

    // readies are flops: low from acceptance until the response is taken
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid_o;
    assign wr_full = (wstrb_reg == 4'hf); // [R2]
    assign wr_off = awaddr_reg[7:0];
    assign wr_bank = awaddr_reg[dcpm_pkg::BANK_SEL_BIT]; // [R1]
    assign wr_ok = wr_full && (wr_off[1:0] == 2'h0) && (wr_off <= dcpm_pkg::OFF_IRQ);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= dcpm_pkg::RESP_OKAY;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr_i;
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata_i;
                wstrb_reg <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_ok ? dcpm_pkg::RESP_OKAY : dcpm_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
        end
    end

    // ==========================================================
    // per-channel register banks and engines
    dcpm_pkg::dcpm_cfg_t cfg [NCH];
    dcpm_pkg::dcpm_stat_t stat [NCH];
    logic [31:0] rd_word [NCH];
    logic [1:0] irq_sel [NCH];
    logic done_flag [NCH];
    logic [7:0] rd_off;
    logic rd_bank;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            logic [15:0] prescale_reg;
            logic [15:0] period_reg;
            logic [15:0] phase_reg;
            logic [15:0] duty_reg;
            logic single_cycle_select_reg;
            logic pol_reg;
            logic run_reg;
            logic [1:0] sel_reg;
            logic done_reg;
            logic tick;
            logic wr_me;
            logic clr_done;
            logic stop_shot;

            // one strobe per writable register keeps the update block flat
            logic wr_pre;
            logic wr_per;
            logic wr_pha;
            logic wr_dut;
            logic wr_ctl;
            logic wr_run;
            logic wr_irq;

            assign wr_me = wr_fire && wr_ok && (wr_bank == 1'(g));
            assign clr_done = wr_me && (wr_off == dcpm_pkg::OFF_IRQ)
                && wdata_reg[dcpm_pkg::IRQ_DONE_BIT]; // [R19]
            assign stop_shot = stat[g].done && single_cycle_select_reg; // [R18]

            assign wr_pre = wr_me && (wr_off == dcpm_pkg::OFF_PRESCALE);
            assign wr_per = wr_me && (wr_off == dcpm_pkg::OFF_PERIOD);
            assign wr_pha = wr_me && (wr_off == dcpm_pkg::OFF_PHASE);
            assign wr_dut = wr_me && (wr_off == dcpm_pkg::OFF_DUTY);

            assign wr_ctl = wr_me && (wr_off == dcpm_pkg::OFF_CTRL);
            assign wr_run = wr_me && (wr_off == dcpm_pkg::OFF_RUN);
            assign wr_irq = wr_me && (wr_off == dcpm_pkg::OFF_IRQ);

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    prescale_reg <= dcpm_pkg::FIELD_RESET;
                    period_reg <= dcpm_pkg::FIELD_RESET;
                    phase_reg <= dcpm_pkg::FIELD_RESET;
                    duty_reg <= dcpm_pkg::FIELD_RESET;
                    single_cycle_select_reg <= 1'b0;
                    pol_reg <= 1'b0;
                    run_reg <= 1'b0;
                    sel_reg <= 2'h0;
                    done_reg <= 1'b0;
                    irq_o[g] <= 1'b0;
                    pulse_out_o[g] <= 1'b1;
                end else begin
                    // upper 16 bits of every field are dropped
                    if (wr_pre)
                        prescale_reg <= wdata_reg[15:0]; // [R4] [R10]
                    if (wr_per)
                        period_reg <= wdata_reg[15:0]; // [R5]
                    if (wr_pha)
                        phase_reg <= wdata_reg[15:0]; // [R6] [R3]
                    if (wr_dut)
                        duty_reg <= wdata_reg[15:0]; // [R7] [R3]
                    if (wr_ctl) begin
                        single_cycle_select_reg <= wdata_reg[dcpm_pkg::CTRL_SINGLE_CYCLE_SELECT_BIT]; // [R8]
                        pol_reg <= wdata_reg[dcpm_pkg::CTRL_POL_BIT]; // [R17]
                    end
                    // a software write in the end cycle wins over the auto-clear
                    if (wr_run)
                        run_reg <= wdata_reg[dcpm_pkg::RUN_START_BIT]; // [R11] [R18]
                    else if (stop_shot)
                        run_reg <= 1'b0; // [R18]
                    if (wr_irq)
                        sel_reg <= wdata_reg[dcpm_pkg::IRQ_SEL_LSB +: 2]; // [R13]
                    // set wins over a simultaneous clear
                    if (stat[g].done)
                        done_reg <= 1'b1; // [R19]
                    else if (clr_done)
                        done_reg <= 1'b0;
                    irq_o[g] <= (done_reg || stat[g].done)
                        && (sel_reg == dcpm_pkg::IRQ_SEL_DONE); // [R14] [R20]
                    pulse_out_o[g] <= stat[g].level; // [R16]
                end
            end

            assign cfg[g] = '{prescale: prescale_reg, period: period_reg,
                phase: phase_reg, duty: duty_reg, single_cycle_select: single_cycle_select_reg,
                polarity: pol_reg, run: run_reg};
            assign irq_sel[g] = sel_reg;
            assign done_flag[g] = done_reg;

            dcpm_tick u_tick (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .run_i(run_reg),
                .prescale_i(prescale_reg),
                .tick_o(tick)
            );

            dcpm_chan u_chan (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .cfg_i(cfg[g]),
                .tick_i(tick),
                .stat_o(stat[g])
            );

            // reserved bits read zero, bits 2..1 of control read zero too
            always_comb begin
                rd_word[g] = 32'h0000_0000; // [R10] [R9]
                unique case (rd_off)
                    dcpm_pkg::OFF_PRESCALE: rd_word[g][15:0] = prescale_reg;
                    dcpm_pkg::OFF_PERIOD: rd_word[g][15:0] = period_reg;
                    dcpm_pkg::OFF_PHASE: rd_word[g][15:0] = phase_reg;
                    dcpm_pkg::OFF_DUTY: rd_word[g][15:0] = duty_reg;
                    dcpm_pkg::OFF_CTRL: begin
                        rd_word[g][dcpm_pkg::CTRL_SINGLE_CYCLE_SELECT_BIT] = single_cycle_select_reg;
                        rd_word[g][dcpm_pkg::CTRL_POL_BIT] = pol_reg;
                    end
                    dcpm_pkg::OFF_RUN: rd_word[g][dcpm_pkg::RUN_START_BIT] = run_reg;
                    dcpm_pkg::OFF_COUNT: rd_word[g][15:0] = stat[g].count; // [R12]
                    dcpm_pkg::OFF_IRQ: begin
                        rd_word[g][dcpm_pkg::IRQ_SEL_LSB +: 2] = sel_reg;
                        rd_word[g][dcpm_pkg::IRQ_DONE_BIT] = done_reg;
                    end
                    default: rd_word[g] = 32'h0000_0000;
                endcase
            end
        end
    endgenerate

    // ==========================================================
    // read path: one outstanding read, data two cycles after the arvalid handshake
    logic [dcpm_pkg::ADDR_W-1:0] araddr_reg;
    logic rd_ok;

    // arready stays low until rdata is taken, so rdata never moves under rvalid
    assign rd_off = araddr_reg[7:0];
    assign rd_bank = araddr_reg[dcpm_pkg::BANK_SEL_BIT];
    assign rd_ok = (rd_off[1:0] == 2'h0) && (rd_off <= dcpm_pkg::OFF_IRQ);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            araddr_reg <= '0;
            s_axi_arready_o <= 1'b1;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            araddr_reg <= s_axi_araddr_i;
            s_axi_arready_o <= 1'b0;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_arready_o <= 1'b1;
        end
    end

    logic rd_pend_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_pend_reg <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= dcpm_pkg::RESP_OKAY;
        end else begin
            rd_pend_reg <= s_axi_arvalid_i && s_axi_arready_o;
            if (rd_pend_reg) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= rd_ok ? rd_word[rd_bank] : 32'h0000_0000;
                s_axi_rresp_o <= rd_ok ? dcpm_pkg::RESP_OKAY : dcpm_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    // ==========================================================
    // checks
    // the stopped level comes from the polarity two edges back, so it must hold still
    a_idle_inactive: assert property (@(posedge clk_i) disable iff (rst_i) // [R22]
        !cfg[0].run ##1 $stable(cfg[0].polarity) ##1 $stable(cfg[0].polarity)
        |-> pulse_out_o[0] == !cfg[0].polarity)
        else $error("stopped channel 0 output not inactive");

    a_single_cycle_select_stop: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
        stat[1].done && cfg[1].single_cycle_select && !wr_fire |=> !cfg[1].run)
        else $error("one-shot did not clear start");

    a_done_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
        stat[1].done |=> done_flag[1])
        else $error("done flag not set after cycle");

    a_irq_gated: assert property (@(posedge clk_i) disable iff (rst_i) // [R20]
        irq_o[0] |-> $past(irq_sel[0]) == dcpm_pkg::IRQ_SEL_DONE)
        else $error("interrupt raised while cause not selected");

    a_irq_raise: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
        done_flag[1] && irq_sel[1] == dcpm_pkg::IRQ_SEL_DONE |=> irq_o[1])
        else $error("selected cause gave no interrupt");

    a_count_bound: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
        cfg[0].run && cfg[0].period >= 16'h0002 && $stable(cfg[0].period)
        |-> stat[0].count < cfg[0].period)
        else $error("count outside period");

    a_partial_err: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
        wr_fire && !wr_full |=> s_axi_bresp_o == dcpm_pkg::RESP_SLVERR)
        else $error("partial write not refused");

    a_read_latency: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
        s_axi_arvalid_i && s_axi_arready_o |-> ##2 s_axi_rvalid_o)
        else $error("read answer late");

    c_single_cycle_select: cover property (@(posedge clk_i) stat[1].done && cfg[1].single_cycle_select);
    c_write_refused: cover property (@(posedge clk_i)
        s_axi_bvalid_o && s_axi_bresp_o == dcpm_pkg::RESP_SLVERR);
    c_read_refused: cover property (@(posedge clk_i)
        s_axi_rvalid_o && s_axi_rresp_o == dcpm_pkg::RESP_SLVERR);
    c_irq: cover property (@(posedge clk_i) irq_o[1]);
    c_both_run: cover property (@(posedge clk_i) cfg[0].run && cfg[1].run);
endmodule : dcpm_top

// File: tb/dcpm_testbench.sv
/*
 * testbench: register, pulse and interrupt checks for the two-channel pulse modulator.
 * assumes: dcpm_top alone, its AXI4-Lite slave driven from here, 25 MHz clock.
 */
`timescale 1ns/1ns
module testbench;
    // ==========================================================
    // clock, reset, bus and pins
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [8:0] awaddr = 9'h000;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [8:0] araddr = 9'h000;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic [1:0] pulse_out;
    logic [1:0] irq;
    int errors = 0;
    int samples_checked = 0;

    always #20 clk_i = ~clk_i;

    dcpm_top #(.NCH(2)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .pulse_out_o(pulse_out), .irq_o(irq)
    );

    // ==========================================================
    // reporting
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic check_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check_resp

    task automatic check_pin(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : check_pin

    // ==========================================================
    // bus master; ready and valid are looked at on the falling edge, where they are settled
    function automatic logic [8:0] adr(input logic ch, input logic [7:0] off);
        return {ch, off};
    endfunction : adr

    task automatic axi_write(input logic [8:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        logic aw_hit;
        logic w_hit;
        @(posedge clk_i);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(negedge clk_i);
        while (awvalid === 1'b1 || wvalid === 1'b1) begin
            aw_hit = awvalid & awready;
            w_hit = wvalid & wready;
            @(posedge clk_i);
            if (aw_hit === 1'b1) awvalid <= 1'b0;
            if (w_hit === 1'b1) wvalid <= 1'b0;
            @(negedge clk_i);
        end
        while (bvalid !== 1'b1) @(negedge clk_i);
        r = bresp;
        @(posedge clk_i);
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [8:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(negedge clk_i);
        while (arready !== 1'b1) @(negedge clk_i);
        @(posedge clk_i);
        arvalid <= 1'b0;
        @(negedge clk_i);
        while (rvalid !== 1'b1) @(negedge clk_i);
        d = rdata;
        r = rresp;
        @(posedge clk_i);
        rready <= 1'b0;
    endtask : axi_read

    task automatic wr_ok(input logic ch, input logic [7:0] off, input logic [31:0] d);
        logic [1:0] r;
        axi_write(adr(ch, off), d, 4'hf, r);
        check_resp("write response", dcpm_pkg::RESP_OKAY, r);
    endtask : wr_ok

    task automatic rd_chk(input logic ch, input logic [7:0] off, input logic [31:0] exp,
                          input string what);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(adr(ch, off), d, r);
        check_resp("read response", dcpm_pkg::RESP_OKAY, r);
        check_word(what, exp, d);
    endtask : rd_chk

    // counting at the level keeps the check free of the exact start latency
    task automatic count_level(input int ch, input logic lvl, input int ncyc, output int n);
        n = 0;
        repeat (ncyc) begin
            @(negedge clk_i);
            n += int'(pulse_out[ch] === lvl);
        end
    endtask : count_level

    // ==========================================================
    // test sequence
    initial begin : main_seq
        int n;
        logic [31:0] d;
        logic [1:0] r;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        check_pin("ch0 idle level", 1'b1, pulse_out[0]);
        check_pin("ch1 idle level", 1'b1, pulse_out[1]);
        check_word("irq after reset", 32'h0, {30'h0, irq});
        for (int ch = 0; ch < 2; ch++) begin
            for (int k = 0; k < 8; k++) begin
                rd_chk(ch[0], 8'(k * 4), 32'h0, "reset value");
            end
        end
        // reserved bits, read-only count, refused accesses
        wr_ok(1'b0, dcpm_pkg::OFF_PRESCALE, 32'hffff_ffff);
        rd_chk(1'b0, dcpm_pkg::OFF_PRESCALE, 32'h0000_ffff, "prescale upper bits");
        wr_ok(1'b0, dcpm_pkg::OFF_CTRL, 32'hffff_fff9);
        rd_chk(1'b0, dcpm_pkg::OFF_CTRL, 32'h0000_0009, "ctrl reserved bits");
        wr_ok(1'b0, dcpm_pkg::OFF_RUN, 32'hffff_fffe);
        rd_chk(1'b0, dcpm_pkg::OFF_RUN, 32'h0, "run upper bits");
        axi_write(adr(1'b0, dcpm_pkg::OFF_COUNT), 32'h0000_1234, 4'hf, r);
        rd_chk(1'b0, dcpm_pkg::OFF_COUNT, 32'h0, "count read only");
        axi_write(adr(1'b0, dcpm_pkg::OFF_PERIOD), 32'h0000_0007, 4'h3, r);
        check_resp("partial write", dcpm_pkg::RESP_SLVERR, r);
        rd_chk(1'b0, dcpm_pkg::OFF_PERIOD, 32'h0, "period after partial write");
        axi_read(9'h020, d, r);
        check_resp("unmapped read", dcpm_pkg::RESP_SLVERR, r);
        check_word("unmapped read data", 32'h0, d);
        // ch0 continuous, negative pulse, cause masked
        wr_ok(1'b0, dcpm_pkg::OFF_PRESCALE, 32'h2);
        wr_ok(1'b0, dcpm_pkg::OFF_PERIOD, 32'h5);
        wr_ok(1'b0, dcpm_pkg::OFF_PHASE, 32'h1);
        wr_ok(1'b0, dcpm_pkg::OFF_DUTY, 32'h2);
        wr_ok(1'b0, dcpm_pkg::OFF_CTRL, 32'h0);
        wr_ok(1'b0, dcpm_pkg::OFF_RUN, 32'h1);
        repeat (20) @(negedge clk_i);
        // three whole periods of 5 ticks x 2 clocks, 2 ticks active each
        count_level(0, 1'b0, 30, n);
        check_word("ch0 active clocks", 32'd12, 32'(n));
        axi_read(adr(1'b0, dcpm_pkg::OFF_COUNT), d, r);
        check_pin("ch0 count below period", 1'b1, d < 32'd5);
        rd_chk(1'b0, dcpm_pkg::OFF_RUN, 32'h1, "ch0 run held");
        rd_chk(1'b0, dcpm_pkg::OFF_IRQ, 32'h1, "ch0 done flag");
        check_pin("ch0 irq masked", 1'b0, irq[0]);
        wr_ok(1'b0, dcpm_pkg::OFF_RUN, 32'h0);
        repeat (4) @(negedge clk_i);
        check_pin("ch0 stopped level", 1'b1, pulse_out[0]);
        rd_chk(1'b0, dcpm_pkg::OFF_COUNT, 32'h0, "ch0 stopped count");
        wr_ok(1'b0, dcpm_pkg::OFF_IRQ, 32'h1);
        rd_chk(1'b0, dcpm_pkg::OFF_IRQ, 32'h0, "ch0 done cleared");
        // ch1 one-shot, positive pulse, done as interrupt cause
        wr_ok(1'b1, dcpm_pkg::OFF_PRESCALE, 32'h3);
        wr_ok(1'b1, dcpm_pkg::OFF_PERIOD, 32'h4);
        wr_ok(1'b1, dcpm_pkg::OFF_PHASE, 32'h2);
        wr_ok(1'b1, dcpm_pkg::OFF_DUTY, 32'h1);
        wr_ok(1'b1, dcpm_pkg::OFF_CTRL, 32'h9);
        wr_ok(1'b1, dcpm_pkg::OFF_IRQ, 32'h100);
        @(negedge clk_i);
        check_pin("ch1 idle positive", 1'b0, pulse_out[1]);
        check_pin("ch0 idle negative", 1'b1, pulse_out[0]);
        wr_ok(1'b1, dcpm_pkg::OFF_RUN, 32'h1);
        count_level(1, 1'b1, 60, n);
        check_word("ch1 one-shot active clocks", 32'd3, 32'(n));
        rd_chk(1'b1, dcpm_pkg::OFF_RUN, 32'h0, "ch1 run cleared");
        rd_chk(1'b1, dcpm_pkg::OFF_IRQ, 32'h101, "ch1 done with cause");
        check_pin("ch1 irq raised", 1'b1, irq[1]);
        check_pin("ch0 irq quiet", 1'b0, irq[0]);
        rd_chk(1'b0, dcpm_pkg::OFF_DUTY, 32'h2, "ch0 duty kept");
        wr_ok(1'b1, dcpm_pkg::OFF_IRQ, 32'h101);
        repeat (2) @(negedge clk_i);
        check_pin("ch1 irq cleared", 1'b0, irq[1]);
        rd_chk(1'b1, dcpm_pkg::OFF_IRQ, 32'h100, "ch1 done cleared");
        close_out();
    end

    // ==========================================================
    // watchdog, well beyond the few hundred clocks the sequence needs
    initial begin : watchdog
        repeat (20000) @(posedge clk_i);
        errors++;
        close_out();
    end
endmodule : testbench
